// *** hdl/wte_engine.v ***
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "wte_consts.vh"

module wte_engine (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    output reg         busy,
    output reg         enable_output,
    output reg         table_overflow_flag,
    output reg         empty_table_flag,
    output reg  [15:0] error_code,
    output reg         irq
);

    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_RD1   = 4'h1;
    localparam [3:0] S_RD2   = 4'h2;
    localparam [3:0] S_HDR   = 4'h3;
    localparam [3:0] S_CHK   = 4'h4;
    localparam [3:0] S_APPW  = 4'h5;
    localparam [3:0] S_DSTW  = 4'h6;
    localparam [3:0] S_SHIFT = 4'h7;
    localparam [3:0] S_SHW   = 4'h8;
    localparam [3:0] S_CNTW  = 4'h9;
    localparam [3:0] S_SRCH  = 4'ha;
    localparam [3:0] S_CMP   = 4'hb;
    localparam [3:0] S_FILL  = 4'hc;
    localparam [3:0] S_DONE  = 4'hd;

    reg [3:0]  state;
    reg [3:0]  ret_state;
    reg [2:0]  op;
    reg [15:0] table_base;
    reg [15:0] data_word;
    reg [15:0] dest_addr;
    reg [15:0] fill_count;
    reg [15:0] search_pattern;
    reg [7:0]  compare_code;
    reg [15:0] search_index;
    reg [15:0] result_word;
    reg [15:0] max_table_length;
    reg [15:0] entry_count;
    reg [15:0] rdata_q;
    reg [15:0] step;
    reg [3:0]  int_status;
    reg [3:0]  int_mask;
    reg [3:0]  events;
    reg        wr_pend;
    reg [11:0] wr_addr;

    wire        bus_acc  = hsel & htrans[1] & hready;
    wire        bus_rd   = bus_acc & ~hwrite;
    wire        ctrl_go  = wr_pend & (wr_addr == `WTE_REG_CTRL) & hwdata[`WTE_CTRL_START];
    wire [2:0]  ctrl_op  = hwdata[`WTE_CTRL_OP_MSB:`WTE_CTRL_OP_LSB];
    wire [16:0] base_x   = {1'b0, table_base};
    wire [16:0] dest_x   = {1'b0, dest_addr};
    wire [16:0] fill_end = dest_x + {1'b0, fill_count} - 17'h00001;
    wire [15:0] step_p1  = step + 16'h0001;

    // signed compare of the current entry against the pattern
    reg cmp_hit;
    always @* begin
        case (compare_code)
            `WTE_CMP_EQ: cmp_hit = ($signed(rdata_q) == $signed(search_pattern));
            `WTE_CMP_NE: cmp_hit = ($signed(rdata_q) != $signed(search_pattern));
            `WTE_CMP_LT: cmp_hit = ($signed(rdata_q) <  $signed(search_pattern));
            `WTE_CMP_GT: cmp_hit = ($signed(rdata_q) >  $signed(search_pattern));
            default:     cmp_hit = 1'b0;
        endcase
    end

    // read mux for the data phase
    reg [31:0] rd_mux;
    always @* begin
        case (haddr[11:0])
            `WTE_REG_CTRL:     rd_mux = {29'h0, op};
            `WTE_REG_BASE:     rd_mux = {16'h0, table_base};
            `WTE_REG_DATA:     rd_mux = {16'h0, data_word};
            `WTE_REG_DEST:     rd_mux = {16'h0, dest_addr};
            `WTE_REG_FILLN:    rd_mux = {16'h0, fill_count};
            `WTE_REG_PATTERN:  rd_mux = {16'h0, search_pattern};
            `WTE_REG_CMP:      rd_mux = {24'h0, compare_code};
            `WTE_REG_INDEX:    rd_mux = {16'h0, search_index};
            `WTE_REG_RESULT:   rd_mux = {16'h0, result_word};
            `WTE_REG_STATUS:   rd_mux = {error_code, 12'h0, empty_table_flag,
                                         table_overflow_flag, enable_output, busy};
            `WTE_REG_INT_STAT: rd_mux = {28'h0, int_status};
            `WTE_REG_INT_MASK: rd_mux = {28'h0, int_mask};
            default:           rd_mux = 32'h0;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata              <= 32'h0;
            hreadyout           <= 1'b1;
            hresp               <= 1'b0;
            wr_pend             <= 1'b0;
            wr_addr             <= 12'h0;
            mem_rd              <= 1'b0;
            mem_wr              <= 1'b0;
            mem_addr            <= `WTE_RST_WORD;
            mem_wdata           <= `WTE_RST_WORD;
            busy                <= 1'b0;
            enable_output       <= 1'b1;
            table_overflow_flag <= 1'b0;
            empty_table_flag    <= 1'b0;
            error_code          <= `WTE_ERR_NONE;
            irq                 <= 1'b0;
            state               <= S_IDLE;
            ret_state           <= S_IDLE;
            op                  <= 3'h0;
            table_base          <= `WTE_RST_WORD;
            data_word           <= `WTE_RST_WORD;
            dest_addr           <= `WTE_RST_WORD;
            fill_count          <= `WTE_RST_WORD;
            search_pattern      <= `WTE_RST_WORD;
            compare_code        <= 8'h0;
            search_index        <= `WTE_RST_WORD;
            result_word         <= `WTE_RST_WORD;
            max_table_length    <= `WTE_RST_WORD;
            entry_count         <= `WTE_RST_WORD;
            rdata_q             <= `WTE_RST_WORD;
            step                <= `WTE_RST_WORD;
            int_status          <= 4'h0;
            int_mask            <= `WTE_RST_MASK;
            events              <= 4'h0;
        end else if (ce) begin
            mem_rd  <= 1'b0;
            mem_wr  <= 1'b0;
            events  <= 4'h0;
            wr_pend <= bus_acc & hwrite;
            wr_addr <= haddr[11:0];
            if (bus_rd) begin
                hrdata <= rd_mux;
            end
            // a read clears the sticky bits, but a new event wins
            if (bus_rd && haddr[11:0] == `WTE_REG_INT_STAT) begin
                int_status <= events;
            end else begin
                int_status <= int_status | events;
            end
            irq <= |(int_status & int_mask);

            // software writes; operands are locked while an operation runs
            if (wr_pend && wr_addr == `WTE_REG_INT_MASK) begin
                int_mask <= hwdata[3:0];
            end
            if (wr_pend && !busy) begin
                case (wr_addr)
                    `WTE_REG_BASE:    table_base     <= hwdata[15:0];
                    `WTE_REG_DATA:    data_word      <= hwdata[15:0];
                    `WTE_REG_DEST:    dest_addr      <= hwdata[15:0];
                    `WTE_REG_FILLN:   fill_count     <= hwdata[15:0];
                    `WTE_REG_PATTERN: search_pattern <= hwdata[15:0];
                    `WTE_REG_CMP:     compare_code   <= hwdata[7:0];
                    `WTE_REG_INDEX:   search_index   <= hwdata[15:0];
                    default:          op             <= op;
                endcase
            end

            case (state)
                S_IDLE: begin
                    // one launch per start write, ignored while busy
                    if (ctrl_go) begin
                        op                  <= ctrl_op;
                        busy                <= 1'b1;
                        enable_output       <= 1'b1;
                        table_overflow_flag <= 1'b0;
                        empty_table_flag    <= 1'b0;
                        error_code          <= `WTE_ERR_NONE;
                        step                <= 16'h0000;
                        state               <= S_DONE;
                        if (ctrl_op == `WTE_OP_FILL) begin
                            if (fill_count == 16'h0000 || fill_count > `WTE_FILL_MAX) begin
                                enable_output <= 1'b0;
                                error_code    <= `WTE_ERR_RANGE;
                            end else if (fill_end > `WTE_ADDR_MAX) begin
                                enable_output <= 1'b0;
                                error_code    <= `WTE_ERR_INDIRECT;
                            end else begin
                                state <= S_FILL;
                            end
                        end else if (ctrl_op == `WTE_OP_SEARCH) begin
                            if (compare_code < `WTE_CMP_EQ || compare_code > `WTE_CMP_GT
                                || search_index > `WTE_MAX_INDEX) begin
                                enable_output <= 1'b0;
                                error_code    <= `WTE_ERR_RANGE;
                            end else if (base_x + 17'h00064 > `WTE_ADDR_MAX) begin
                                enable_output <= 1'b0;
                                error_code    <= `WTE_ERR_INDIRECT;
                            end else begin
                                // base already points at the count word
                                mem_rd    <= 1'b1;
                                mem_addr  <= table_base;
                                ret_state <= S_CHK;
                                state     <= S_RD1;
                            end
                        end else if (ctrl_op == `WTE_OP_APPEND || ctrl_op == `WTE_OP_OLDEST
                                     || ctrl_op == `WTE_OP_NEWEST) begin
                            if (base_x + 17'h00065 > `WTE_ADDR_MAX
                                || (ctrl_op != `WTE_OP_APPEND && dest_x > `WTE_ADDR_MAX)) begin
                                enable_output <= 1'b0;
                                error_code    <= `WTE_ERR_INDIRECT;
                            end else begin
                                mem_rd    <= 1'b1;
                                mem_addr  <= table_base;
                                ret_state <= S_HDR;
                                state     <= S_RD1;
                            end
                        end else begin
                            enable_output <= 1'b0;
                            error_code    <= `WTE_ERR_RANGE;
                        end
                    end
                end
                S_RD1: begin
                    state <= S_RD2;
                end
                S_RD2: begin
                    rdata_q <= mem_rdata;
                    state   <= ret_state;
                end
                S_HDR: begin
                    max_table_length <= rdata_q;
                    mem_rd           <= 1'b1;
                    mem_addr         <= table_base + 16'h0001;
                    ret_state        <= S_CHK;
                    state            <= S_RD1;
                end
                S_CHK: begin
                    entry_count <= rdata_q;
                    state       <= S_DONE;
                    if (op == `WTE_OP_SEARCH) begin
                        if (rdata_q > `WTE_MAX_ENTRIES) begin
                            enable_output <= 1'b0;
                            error_code    <= `WTE_ERR_RANGE;
                        end else begin
                            step  <= search_index;
                            state <= S_SRCH;
                        end
                    end else if (max_table_length > `WTE_MAX_ENTRIES
                                 || rdata_q > max_table_length) begin
                        enable_output <= 1'b0;
                        error_code    <= `WTE_ERR_RANGE;
                    end else if (op == `WTE_OP_APPEND) begin
                        if (rdata_q >= max_table_length) begin
                            enable_output       <= 1'b0;
                            table_overflow_flag <= 1'b1;
                            events[`WTE_IRQ_OVERFLOW] <= 1'b1;
                        end else begin
                            mem_wr    <= 1'b1;
                            mem_addr  <= table_base + 16'h0002 + rdata_q;
                            mem_wdata <= data_word;
                            state     <= S_APPW;
                        end
                    end else if (rdata_q == 16'h0000) begin
                        enable_output    <= 1'b0;
                        empty_table_flag <= 1'b1;
                        events[`WTE_IRQ_EMPTY] <= 1'b1;
                    end else begin
                        mem_rd    <= 1'b1;
                        ret_state <= S_DSTW;
                        state     <= S_RD1;
                        if (op == `WTE_OP_OLDEST) begin
                            mem_addr <= table_base + 16'h0002;
                        end else begin
                            mem_addr <= table_base + 16'h0001 + rdata_q;
                        end
                    end
                end
                S_APPW: begin
                    mem_wr    <= 1'b1;
                    mem_addr  <= table_base + 16'h0001;
                    mem_wdata <= entry_count + 16'h0001;
                    state     <= S_DONE;
                end
                S_DSTW: begin
                    result_word <= rdata_q;
                    mem_wr      <= 1'b1;
                    mem_addr    <= dest_addr;
                    mem_wdata   <= rdata_q;
                    step        <= 16'h0001;
                    state       <= (op == `WTE_OP_OLDEST) ? S_SHIFT : S_CNTW;
                end
                S_SHIFT: begin
                    if (step < entry_count) begin
                        mem_rd    <= 1'b1;
                        mem_addr  <= table_base + 16'h0002 + step;
                        ret_state <= S_SHW;
                        state     <= S_RD1;
                    end else begin
                        state <= S_CNTW;
                    end
                end
                S_SHW: begin
                    mem_wr    <= 1'b1;
                    mem_addr  <= table_base + 16'h0001 + step;
                    mem_wdata <= rdata_q;
                    step      <= step_p1;
                    state     <= S_SHIFT;
                end
                S_CNTW: begin
                    mem_wr    <= 1'b1;
                    mem_addr  <= table_base + 16'h0001;
                    mem_wdata <= entry_count - 16'h0001;
                    state     <= S_DONE;
                end
                S_SRCH: begin
                    if (step < entry_count) begin
                        mem_rd    <= 1'b1;
                        mem_addr  <= table_base + 16'h0001 + step;
                        ret_state <= S_CMP;
                        state     <= S_RD1;
                    end else begin
                        search_index <= entry_count;
                        state        <= S_DONE;
                    end
                end
                S_CMP: begin
                    if (cmp_hit) begin
                        search_index <= step;
                        state        <= S_DONE;
                    end else begin
                        step  <= step_p1;
                        state <= S_SRCH;
                    end
                end
                S_FILL: begin
                    mem_wr    <= 1'b1;
                    mem_addr  <= dest_addr + step;
                    mem_wdata <= data_word;
                    step      <= step_p1;
                    if (step_p1 == fill_count) begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy  <= 1'b0;
                    state <= S_IDLE;
                    events[`WTE_IRQ_DONE] <= 1'b1;
                    if (error_code != `WTE_ERR_NONE) begin
                        events[`WTE_IRQ_ERROR] <= 1'b1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// *** hdl/wte_consts.vh ***
`ifndef WTE_CONSTS_VH
`define WTE_CONSTS_VH

// register byte offsets
`define WTE_REG_CTRL       12'h000
`define WTE_REG_BASE       12'h004
`define WTE_REG_DATA       12'h008
`define WTE_REG_DEST       12'h00c
`define WTE_REG_FILLN      12'h010
`define WTE_REG_PATTERN    12'h014
`define WTE_REG_CMP        12'h018
`define WTE_REG_INDEX      12'h01c
`define WTE_REG_RESULT     12'h020
`define WTE_REG_STATUS     12'h024
`define WTE_REG_INT_STAT   12'h028
`define WTE_REG_INT_MASK   12'h02c

// control register fields
`define WTE_CTRL_OP_LSB    0
`define WTE_CTRL_OP_MSB    2
`define WTE_CTRL_START     3

// operation codes
`define WTE_OP_APPEND      3'h1
`define WTE_OP_OLDEST      3'h2
`define WTE_OP_NEWEST      3'h3
`define WTE_OP_SEARCH      3'h4
`define WTE_OP_FILL        3'h5

// compare codes
`define WTE_CMP_EQ         8'h01
`define WTE_CMP_NE         8'h02
`define WTE_CMP_LT         8'h03
`define WTE_CMP_GT         8'h04

// status register fields
`define WTE_ST_BUSY        0
`define WTE_ST_ENABLE      1
`define WTE_ST_OVERFLOW    2
`define WTE_ST_EMPTY       3
`define WTE_ST_ERR_LSB     16

// interrupt status / mask bits
`define WTE_IRQ_DONE       0
`define WTE_IRQ_OVERFLOW   1
`define WTE_IRQ_EMPTY      2
`define WTE_IRQ_ERROR      3

// error codes
`define WTE_ERR_NONE       16'h0000
`define WTE_ERR_INDIRECT   16'h0006
`define WTE_ERR_RANGE      16'h0091

// table and fill limits
`define WTE_MAX_ENTRIES    16'h0064
`define WTE_MAX_INDEX      16'h0063
`define WTE_FILL_MAX       16'h00ff
`define WTE_ADDR_MAX       17'h0efff

// reset values
`define WTE_RST_WORD       16'h0000
`define WTE_RST_MASK       4'h0

`endif

// *** verif/wte_mem.sv ***
`timescale 1ns/100ps
module wte_mem (
    input  wire        hclk,
    input  wire        mem_rd,
    input  wire        mem_wr,
    input  wire [15:0] mem_addr,
    input  wire [15:0] mem_wdata,
    output reg  [15:0] mem_rdata
);
    reg [15:0] mem [0:4095];
    initial mem_rdata = 16'h0000;
    // read data stands only in the cycle after the pulse, then toggles every cycle
    always @(posedge hclk) begin
        mem_rdata <= mem_rd ? mem[mem_addr[11:0]] : ~mem_rdata;
        if (mem_wr)
            mem[mem_addr[11:0]] <= mem_wdata;
    end
endmodule

// *** verif/wte_checker.sv ***
`timescale 1ns/100ps
`include "wte_consts.vh"
module wte_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        mem_rd,
    input wire        mem_wr,
    input wire [15:0] mem_addr,
    input wire        busy,
    input wire        enable_output,
    input wire        table_overflow_flag,
    input wire        empty_table_flag,
    input wire [15:0] error_code
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ovf; table_overflow_flag |-> !enable_output; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow with enable high");
    property p_empty; empty_table_flag |-> !enable_output; endproperty
    a_empty: assert property (p_empty) else $error("empty flag with enable high");
    property p_err; error_code != 16'h0000 |-> !enable_output; endproperty
    a_err: assert property (p_err) else $error("error code with enable high");
    property p_code; error_code == 16'h0000 || error_code == 16'h0006 || error_code == 16'h0091;
    endproperty
    a_code: assert property (p_code) else $error("unknown error code");
    property p_addr; mem_rd || mem_wr |-> {1'b0, mem_addr} <= `WTE_ADDR_MAX; endproperty
    a_addr: assert property (p_addr) else $error("memory access above limit");
    property p_gap; mem_rd |=> (!mem_rd && !mem_wr) [*2]; endproperty
    a_gap: assert property (p_gap) else $error("memory request too soon after read");
    property p_excl; !(mem_rd && mem_wr); endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    property p_done; $rose(busy) |-> ##[1:1000] !busy; endproperty
    a_done: assert property (p_done) else $error("operation never ended");
    property p_mem; mem_rd || mem_wr |-> busy; endproperty
    a_mem: assert property (p_mem) else $error("memory access while idle");
endmodule
bind wte_engine wte_checker wte_checker_i (.hclk(hclk), .hresetn(hresetn), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .busy(busy), .enable_output(enable_output),
    .table_overflow_flag(table_overflow_flag), .empty_table_flag(empty_table_flag),
    .error_code(error_code));

// *** verif/tb.sv ***
`timescale 1ns/100ps
`include "wte_consts.vh"
module tb;
    reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, sc;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  hsize = 3'h2;
    reg  [15:0] v [0:3];
    reg  [15:0] fv;
    reg  [47:0] ec;
    reg  [95:0] n;
    reg  [95:0] notes [$];
    wire [31:0] hrdata;
    wire [15:0] mem_addr, mem_wdata, mem_rdata;
    wire        hreadyout, hresp, mem_rd, mem_wr, busy, irq;
    reg         ce = 1'b1;
    integer     mismatches = 0, tests_run = 0, guard = 0, k;
    localparam [15:0]  B = 16'h0100, D = 16'h0200, F = 16'h0300;
    localparam [223:0] SC = {32'h04043204, 32'h01003205, 32'h01010503, 32'h04000502,
                             32'h03000501, 32'h02000501, 32'h01000500};
    localparam [79:0]  ST = {16'h0064, 16'h0005, 16'h0007, 16'hfffd, 16'h0005};
    localparam [431:0] EC = {48'h3004efa00006, 48'h100401000091, 48'h401c00640091,
                             48'h401800010000, 48'h401800050091, 48'h500cefff0006,
                             48'h501000020000, 48'h501001000091, 48'h501000000091};
    always #2.5 hclk = ~hclk;
    wte_engine wte_engine_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .busy(busy), .enable_output(), .table_overflow_flag(), .empty_table_flag(),
        .error_code(), .irq(irq), .hresp(hresp));
    wte_mem wte_mem_i (.hclk(hclk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    task stop_test;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task cmp(input [63:0] nm, input [31:0] e, input [31:0] s);
        tests_run = tests_run + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, s);
        end
    endtask
    task tick;
        @(posedge hclk);
        guard = guard + 1;
        if (guard > 3000) begin
            mismatches = mismatches + 1;
            stop_test;
        end
    endtask
    task bus(input [11:0] a, input w, input [31:0] d);
        guard = 0;
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        tick;
        while (hreadyout !== 1'b1) tick;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        tick;
        while (hreadyout !== 1'b1) tick;
    endtask
    task rd(input [11:0] a, input [31:0] m, input [31:0] e);
        notes.push_back({20'h0, a, m, e});
        bus(a, 1'b0, 32'h0);
    endtask
    task op(input [2:0] c);
        bus(`WTE_REG_CTRL, 1'b1, {28'h0, 1'b1, c});
        tick;
        while (busy !== 1'b0) tick;
    endtask
    // one note is consumed for each read data phase
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            cmp("hrdata", n[31:0], hrdata & n[63:32]);
            cmp("hresp", 32'h0, {31'h0, hresp});
        end
        if (hreadyout === 1'b1)
            rd_dp <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        void'($urandom(32'h7628e2ec));
        for (k = 0; k < 12; k = k + 1) @(posedge hclk);
        hresetn <= 1'b1;
        tick;
        rd(`WTE_REG_STATUS, 32'hffffffff, 32'h2);
        rd(`WTE_REG_INT_MASK, 32'hffffffff, 32'h0);
        rd(12'h030, 32'hffffffff, 32'h0);
        $display("end reset values");
        wte_mem_i.mem[B] = 16'h0003;
        wte_mem_i.mem[B+1] = 16'h0000;
        wte_mem_i.mem[B+5] = 16'h5a5a;
        bus(`WTE_REG_BASE, 1'b1, {16'h0, B});
        for (k = 0; k < 4; k = k + 1) begin
            v[k] = 16'($urandom);
            bus(`WTE_REG_DATA, 1'b1, {16'h0, v[k]});
            op(`WTE_OP_APPEND);
            rd(`WTE_REG_STATUS, 32'hffff000f, k < 3 ? 32'h2 : 32'h4);
        end
        for (k = 0; k < 3; k = k + 1)
            cmp("entry", {16'h0, v[k]}, {16'h0, wte_mem_i.mem[B+2+k]});
        cmp("count", 32'h3, {16'h0, wte_mem_i.mem[B+1]});
        cmp("spare", 32'h5a5a, {16'h0, wte_mem_i.mem[B+5]});
        $display("end append");
        bus(`WTE_REG_DEST, 1'b1, {16'h0, D});
        op(`WTE_OP_NEWEST);
        cmp("dest", {16'h0, v[2]}, {16'h0, wte_mem_i.mem[D]});
        rd(`WTE_REG_RESULT, 32'h0000ffff, {16'h0, v[2]});
        op(`WTE_OP_OLDEST);
        cmp("dest", {16'h0, v[0]}, {16'h0, wte_mem_i.mem[D]});
        cmp("entry0", {16'h0, v[1]}, {16'h0, wte_mem_i.mem[B+2]});
        cmp("count", 32'h1, {16'h0, wte_mem_i.mem[B+1]});
        op(`WTE_OP_OLDEST);
        op(`WTE_OP_NEWEST);
        rd(`WTE_REG_STATUS, 32'hffff000f, 32'h8);
        cmp("count", 32'h0, {16'h0, wte_mem_i.mem[B+1]});
        $display("end removal");
        wte_mem_i.mem[B] = 16'h0065;
        wte_mem_i.mem[B+1] = 16'h0005;
        for (k = 0; k < 5; k = k + 1) wte_mem_i.mem[B+2+k] = ST[16*k +: 16];
        bus(`WTE_REG_BASE, 1'b1, {16'h0, B + 16'h0001});
        for (k = 0; k < 7; k = k + 1) begin
            sc = SC[32*k +: 32];
            bus(`WTE_REG_CMP, 1'b1, {24'h0, sc[31:24]});
            bus(`WTE_REG_INDEX, 1'b1, {24'h0, sc[23:16]});
            bus(`WTE_REG_PATTERN, 1'b1, {24'h0, sc[15:8]});
            op(`WTE_OP_SEARCH);
            rd(`WTE_REG_INDEX, 32'h0000ffff, {24'h0, sc[7:0]});
        end
        $display("end search");
        fv = 16'($urandom);
        wte_mem_i.mem[F+255] = ~fv;
        bus(`WTE_REG_DATA, 1'b1, {16'h0, fv});
        bus(`WTE_REG_DEST, 1'b1, {16'h0, F});
        bus(`WTE_REG_FILLN, 1'b1, 32'h000000ff);
        op(`WTE_OP_FILL);
        for (k = 0; k < 256; k = k + 1)
            cmp("fill", {16'h0, k < 255 ? fv : ~fv}, {16'h0, wte_mem_i.mem[F+k]});
        $display("end fill");
        for (k = 0; k < 9; k = k + 1) begin
            ec = EC[48*k +: 48];
            bus(ec[43:32], 1'b1, {16'h0, ec[31:16]});
            op(ec[46:44]);
            rd(`WTE_REG_STATUS, 32'hffff000f,
               ec[15:0] == 16'h0 ? 32'h2 : {ec[15:0], 16'h0});
        end
        $display("end errors");
        rd(`WTE_REG_INT_STAT, 32'h0, 32'h0);
        op(`WTE_OP_FILL);
        tick;
        tick;
        cmp("irq", 32'h0, {31'h0, irq});
        bus(`WTE_REG_INT_MASK, 1'b1, 32'h00000001);
        tick;
        tick;
        cmp("irq", 32'h1, {31'h0, irq});
        rd(`WTE_REG_INT_STAT, 32'h0000000f, 32'h9);
        rd(`WTE_REG_INT_STAT, 32'h0000000f, 32'h0);
        tick;
        tick;
        cmp("irq", 32'h0, {31'h0, irq});
        $display("end interrupts");
        // a write issued while the clock enable is low must not land
        ce <= 1'b0;
        bus(`WTE_REG_INT_MASK, 1'b1, 32'h00000000);
        ce <= 1'b1;
        rd(`WTE_REG_INT_MASK, 32'h0000000f, 32'h1);
        $display("end clock enable");
        stop_test;
    end
endmodule
